// ---- logic/dpbm_block_memory.sv ----
// Purpose: dual-port block memory, 36 Kb full size or 18 Kb half size
// Assumes: both ports run on clk_sys; config inputs held static
// Notes: split mode writes on port 0 and reads on port 1
// Summary of operation
// - Full block serves 32Kx1 up to 1Kx36, and 512x72 in split mode.
// - Half block serves 16Kx1 up to 512x36, and 256x72 in split mode.
// - Ports are independent, share only contents; read and write widths may differ.
// - Split mode: port 0 write-only, port 1 read-only, width doubled.
// - A selector picks split mode or two full ports per instance.
// - Two full blocks cascade into 64Kx1 through cascade in and out; cascade in reaches the output only through the pipe register.
// - Ports of 18, 36 or 72 bits have one write enable per byte.
// - A write and a read each complete on one clock edge.
// - Write enable decides read or read-during-write; three write behaviours.
// - Outputs hold until that port reads or writes again; latch mode default.
// - Optional pipe register adds one cycle of read latency.
// - Separate resets load pipe register and latch with the init value.
// - With pipe enabled, pipe reset loads init; precedence picks reset versus enable.
// - With enable precedence, pipe reset acts only with enable; latch untouched.
// - Latch reset loads init in any pipe setting, only while port enabled.
// - Parity bits exist only at widths 9, 18, 36 and 72.
// - Opposite port narrow makes 9, 18, 36 behave as 8, 16, 32.
// - Disabled port writes nothing; in two-port latch mode its output keeps its value.
// - New-data shows written data, old-data prior contents, hold keeps output.
`timescale 1ns/1ps
module dpbm_block_memory #(
  parameter bit         HALF_SIZE    = 1'b0,
  parameter logic [1:0] CASCADE_ROLE = dpbm_pkg::DPBM_CAS_NONE
) (
  // Clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst,
  // Configuration, low selects two full ports
  input  wire logic                                 splitReadWriteMode,
  input  wire logic [1:0][2:0]                      readWidth,
  input  wire logic [1:0][2:0]                      writeWidth,
  input  wire logic [1:0][1:0]                      writeMode,
  input  wire logic [1:0]                           pipeStageSelect,
  input  wire logic [1:0]                           pipeResetPrecedence,
  input  wire logic [1:0][dpbm_pkg::DPBM_OUT_W-1:0] outputInitValue,
  // Port access
  input  wire logic [1:0]                           portEnable,
  input  wire logic [1:0][3:0]                      writeEnable,
  input  wire logic [1:0][dpbm_pkg::DPBM_ADDR_W-1:0] portAddr,
  input  wire logic [1:0]                           cascadeTopAddressBit,
  input  wire logic [1:0][dpbm_pkg::DPBM_DATA_W-1:0] dataIn,
  input  wire logic [1:0][dpbm_pkg::DPBM_PAR_W-1:0] parityInBus,
  // Output controls
  input  wire logic [1:0]                           outputLatchReset,
  input  wire logic [1:0]                           outputPipeReset,
  input  wire logic [1:0]                           pipeClockEnable,
  // Cascade
  input  wire logic [1:0]                           cascadeIn,
  output wire logic [1:0]                           cascadeOut,
  // Read data
  output wire logic [1:0][dpbm_pkg::DPBM_DATA_W-1:0] dataOut,
  output wire logic [1:0][dpbm_pkg::DPBM_PAR_W-1:0] parityOutBus
);
  import dpbm_pkg::*;

  localparam int WORDS = HALF_SIZE ? DPBM_HALF_WORDS : DPBM_FULL_WORDS;
  localparam int WAW   = $clog2(WORDS);

  if (CASCADE_ROLE > DPBM_CAS_UPPER ||
      (HALF_SIZE && CASCADE_ROLE != DPBM_CAS_NONE)) begin : g_bad_cascade
    $error("dpbm_block_memory: cascade needs a full block and a valid role");
  end

  typedef struct packed {
    logic [1:0] casLower;
  } dpbm_main_t;

  dpbm_main_t main_reg;
  dpbm_main_t main_next;

  logic                  parOk;
  logic [1:0]            hit;
  logic [1:0]            doWr;
  logic [1:0]            doRd;
  logic [1:0]            rdLoad;
  logic [1:0]            stLoad;
  logic [1:0]            stEn;
  logic [1:0][63:0]      din;
  logic [1:0][7:0]       pin;
  logic [1:0][7:0]       wen;
  logic [1:0][WAW-1:0]   wAddr;
  logic [1:0][WAW-1:0]   rAddr;
  logic [1:0][71:0]      wMask;
  logic [1:0][71:0]      wData;
  logic [1:0][71:0]      oldWord;
  logic [1:0][71:0]      newWord;
  logic [1:0][71:0]      picked;
  logic [1:0][35:0]      stData;
  logic [1:0][35:0]      stOut;

  always_comb begin
    main_next = main_reg;
    parOk = 1'b1;
    for (int i = 0; i < 2; i++) begin
      if (readWidth[i] < DPBM_W9 || writeWidth[i] < DPBM_W9) begin
        parOk = 1'b0;
      end
    end
    for (int i = 0; i < 2; i++) begin
      // Top address bit steers which cascaded block answers
      hit[i] = CASCADE_ROLE == DPBM_CAS_NONE ||
               cascadeTopAddressBit[i] ==
               (CASCADE_ROLE == DPBM_CAS_UPPER);
      doWr[i] = portEnable[i] && hit[i] &&
                (|writeEnable[i] || (splitReadWriteMode && |writeEnable[1])) &&
                !(splitReadWriteMode && i == 1);
      doRd[i] = portEnable[i] && hit[i] &&
                !(splitReadWriteMode && i == 0);
      if (splitReadWriteMode) begin
        din[i] = {dataIn[1], dataIn[0]};
        pin[i] = {parityInBus[1], parityInBus[0]};
        wen[i] = {writeEnable[1], writeEnable[0]};
      end else begin
        din[i] = {32'h0, dataIn[i]};
        pin[i] = {4'h0, parityInBus[i]};
        wen[i] = {4'h0, writeEnable[i]};
      end
      {wMask[i], wData[i]} = dpbm_place(writeWidth[i], portAddr[i],
                                        din[i], pin[i], wen[i],
                                        parOk);
      wAddr[i] = WAW'(dpbm_word(writeWidth[i], portAddr[i]));
      rAddr[i] = WAW'(dpbm_word(readWidth[i], portAddr[i]));
      newWord[i] = oldWord[i];
      if (wAddr[i] == rAddr[i]) begin
        newWord[i] = (oldWord[i] & ~wMask[i]) | (wData[i] & wMask[i]);
      end
      // Write enable picks read or read-during-write
      picked[i] = dpbm_pick(readWidth[i], portAddr[i], oldWord[i], parOk);
      rdLoad[i] = doRd[i];
      if (doWr[i] && doRd[i]) begin
        case (writeMode[i])
          DPBM_NEW_DATA: begin
            picked[i] = dpbm_pick(readWidth[i], portAddr[i],
                                  newWord[i], parOk);
          end
          DPBM_OLD_DATA: begin
            rdLoad[i] = 1'b1;
          end
          default: begin
            rdLoad[i] = 1'b0;
          end
        endcase
      end
      if (CASCADE_ROLE == DPBM_CAS_UPPER && portEnable[i]) begin
        main_next.casLower[i] = !cascadeTopAddressBit[i];
      end
    end
    stData[0] = {picked[0][67:64], picked[0][31:0]};
    stData[1] = {picked[1][67:64], picked[1][31:0]};
    stLoad = rdLoad;
    stEn = portEnable;
    if (splitReadWriteMode) begin
      // Wide read word spreads over both output stages
      stData[0] = {picked[1][67:64], picked[1][31:0]};
      stData[1] = {picked[1][71:68], picked[1][63:32]};
      stLoad = {rdLoad[1], rdLoad[1]};
      stEn = {portEnable[1], portEnable[1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_reg <= '0;
    end else begin
      main_reg <= main_next;
    end
  end

  dpbm_array #(
    .WORDS (WORDS),
    .AW    (WAW)
  ) u_array (
    .clk_sys (clk_sys),
    .wrEn    (doWr),
    .wrAddr  (wAddr),
    .wrMask  (wMask),
    .wrData  (wData),
    .rdAddr  (rAddr),
    .rdWord  (oldWord)
  );

  for (genvar g = 0; g < 2; g++) begin : g_port
    dpbm_out_stage u_out (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .loadEn          (stLoad[g]),
      .loadData        (stData[g]),
      .portEnable      (stEn[g]),
      .latchReset      (outputLatchReset[g]),
      .pipeSel         (pipeStageSelect[g]),
      .pipeClockEnable (pipeClockEnable[g]),
      .pipeReset       (outputPipeReset[g]),
      .pipePrecedence  (pipeResetPrecedence[g]),
      .initValue       (outputInitValue[g]),
      .casSel          (main_reg.casLower[g]),
      .casBit          (cascadeIn[g]),
      .dataOut         (stOut[g])
    );
    assign dataOut[g] = stOut[g][31:0];
    assign parityOutBus[g] = stOut[g][35:32];
    assign cascadeOut[g] = stOut[g][0];
  end

  // Checks on port 0, plus a split-mode check of both ports; p0Wide: two-port mode, 36-bit widths, no cascade
  logic p0Wide;
  assign p0Wide = !splitReadWriteMode && CASCADE_ROLE == DPBM_CAS_NONE &&
                  readWidth[0] == DPBM_W36 && writeWidth[0] == DPBM_W36;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_idle_hold;
    !portEnable[0] && !splitReadWriteMode && !pipeStageSelect[0]
      |=> !pipeStageSelect[0] -> $stable(dataOut[0]);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("disabled port changed its output");

  property p_latch_reset;
    portEnable[0] && outputLatchReset[0] && !pipeStageSelect[0] &&
      !splitReadWriteMode |=> dataOut[0] == $past(outputInitValue[0][31:0]);
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("latch reset did not load the init value");

  property p_new_data;
    p0Wide && !pipeStageSelect[0] && writeMode[0] == DPBM_NEW_DATA &&
      portEnable[0] && writeEnable[0] == 4'hf && !outputLatchReset[0]
      |=> dataOut[0] == $past(dataIn[0]);
  endproperty
  a_new_data: assert property (p_new_data)
    else $error("new-data write not shown on output");

  sequence s_full_write;
    p0Wide && !pipeStageSelect[0] && portEnable[0] && !portEnable[1] &&
      writeEnable[0] == 4'hf && !outputLatchReset[0];
  endsequence

  property p_old_data;
    s_full_write ##1 (s_full_write and (writeMode[0] == DPBM_OLD_DATA &&
      portAddr[0] == $past(portAddr[0])))
      |=> dataOut[0] == $past(dataIn[0], 2);
  endproperty
  a_old_data: assert property (p_old_data)
    else $error("old-data write did not show prior contents");

  property p_hold_mode;
    p0Wide && !pipeStageSelect[0] && writeMode[0] == DPBM_HOLD_OUT &&
      portEnable[0] && |writeEnable[0] && !outputLatchReset[0]
      |=> $stable(dataOut[0]);
  endproperty
  a_hold_mode: assert property (p_hold_mode)
    else $error("hold mode changed the output on a write");

  property p_byte_lane;
    p0Wide && !pipeStageSelect[0] && writeMode[0] == DPBM_NEW_DATA &&
      portEnable[0] && writeEnable[0] == 4'h5 && !outputLatchReset[0]
      |=> dataOut[0][23:16] == $past(dataIn[0][23:16]) &&
          dataOut[0][7:0] == $past(dataIn[0][7:0]);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte lane write not stored");

  property p_pipe_latency;
    (p0Wide && pipeStageSelect[0] && writeMode[0] == DPBM_NEW_DATA &&
      portEnable[0] && writeEnable[0] == 4'hf && !outputLatchReset[0])
      ##1 (pipeStageSelect[0] && pipeClockEnable[0] && !outputPipeReset[0])
      |=> dataOut[0] == $past(dataIn[0], 2);
  endproperty
  a_pipe_latency: assert property (p_pipe_latency)
    else $error("pipe stage latency is not two edges");

  property p_pipe_reset;
    pipeStageSelect[0] && outputPipeReset[0] &&
      pipeResetPrecedence[0] == DPBM_PREC_RESET
      |=> dataOut[0] == $past(outputInitValue[0][31:0]);
  endproperty
  a_pipe_reset: assert property (p_pipe_reset)
    else $error("pipe reset did not load the init value");

  property p_ce_first;
    pipeStageSelect[0] && outputPipeReset[0] && !pipeClockEnable[0] &&
      pipeResetPrecedence[0] == DPBM_PREC_CE
      |=> pipeStageSelect[0] -> $stable(dataOut[0]);
  endproperty
  a_ce_first: assert property (p_ce_first)
    else $error("pipe reset acted without clock enable");

  property p_split_wide;
    (splitReadWriteMode && CASCADE_ROLE == DPBM_CAS_NONE &&
      writeWidth[0] == DPBM_W72 && readWidth[1] == DPBM_W72 &&
      portEnable[0] && &writeEnable[0] && &writeEnable[1] && !HALF_SIZE)
      ##1 (portEnable[1] && portAddr[1] == $past(portAddr[0]) &&
      !outputLatchReset[0] && !outputLatchReset[1] &&
      !pipeStageSelect[0] && !pipeStageSelect[1])
      |=> dataOut[1] == $past(dataIn[1], 2) &&
          dataOut[0] == $past(dataIn[0], 2);
  endproperty
  a_split_wide: assert property (p_split_wide)
    else $error("split mode wide word not read back");

  c_split_read: cover property (splitReadWriteMode && portEnable[1]);
  c_pipe_reset: cover property (pipeStageSelect[0] && outputPipeReset[0]);
  c_new_write: cover property (p0Wide && portEnable[0] && &writeEnable[0]);

endmodule // dpbm_block_memory

// ---- logic/dpbm_pkg.sv ----
// Purpose: shared constants and lane mapping for the dual-port block memory
// Assumes: physical words of 72 bits made of eight 9-bit lanes
// Notes: a lane holds one data byte in bits 7:0 and its parity bit above
package dpbm_pkg;

  // Width codes, x1 up to x72
  localparam logic [2:0] DPBM_W1  = 3'h0;
  localparam logic [2:0] DPBM_W9  = 3'h3;
  localparam logic [2:0] DPBM_W36 = 3'h5;
  localparam logic [2:0] DPBM_W72 = 3'h6;

  // Read-during-write behaviour
  localparam logic [1:0] DPBM_NEW_DATA = 2'h0;
  localparam logic [1:0] DPBM_OLD_DATA = 2'h1;
  localparam logic [1:0] DPBM_HOLD_OUT = 2'h2;

  // Cascade role of an instance
  localparam logic [1:0] DPBM_CAS_NONE  = 2'h0;
  localparam logic [1:0] DPBM_CAS_LOWER = 2'h1;
  localparam logic [1:0] DPBM_CAS_UPPER = 2'h2;

  // Pipe reset precedence
  localparam logic DPBM_PREC_RESET = 1'b0;
  localparam logic DPBM_PREC_CE    = 1'b1;

  // Geometry
  localparam int DPBM_PHYS_W     = 72;
  localparam int DPBM_LANE_W     = 9;
  localparam int DPBM_BYTE_W     = 8;
  localparam int DPBM_WIDE_SHIFT = 6;
  localparam int DPBM_FULL_WORDS = 512;
  localparam int DPBM_HALF_WORDS = 256;
  localparam int DPBM_ADDR_W     = 15;
  localparam int DPBM_DATA_W     = 32;
  localparam int DPBM_PAR_W      = 4;
  localparam int DPBM_OUT_W      = 36;

  // Elements per physical word is two to this power
  function automatic int dpbm_shift(logic [2:0] c);
    return DPBM_WIDE_SHIFT - int'(c);
  endfunction

  function automatic logic [8:0] dpbm_word(logic [2:0] c, logic [14:0] a);
    return 9'(a >> dpbm_shift(c));
  endfunction

  // Returns {mask, data} of a port write placed in a physical word
  function automatic logic [143:0] dpbm_place(logic [2:0] c,
      logic [14:0] a, logic [63:0] d, logic [7:0] p, logic [7:0] we,
      logic par);
    logic [71:0] m;
    logic [71:0] v;
    int          elem, lane, k, db, li, ls;
    m = '0;
    v = '0;
    elem = int'(a) & ((1 << dpbm_shift(c)) - 1);
    ls = int'(c) - int'(DPBM_W9);
    for (int i = 0; i < DPBM_PHYS_W; i++) begin
      lane = i / DPBM_LANE_W;
      k = i % DPBM_LANE_W;
      db = lane * DPBM_BYTE_W + k;
      if (c < DPBM_W9) begin
        if (k < DPBM_BYTE_W && (db >> c) == elem) begin
          m[i] = we[0];
          v[i] = d[db & ((1 << c) - 1)];
        end
      end else if ((lane >> ls) == elem) begin
        li = lane & ((1 << ls) - 1);
        m[i] = we[li] && (k < DPBM_BYTE_W || par);
        v[i] = (k < DPBM_BYTE_W) ? d[li * DPBM_BYTE_W + k] : p[li];
      end
    end
    return {m, v};
  endfunction

  // Returns {parity, data} read from a physical word
  function automatic logic [71:0] dpbm_pick(logic [2:0] c,
      logic [14:0] a, logic [71:0] w, logic par);
    logic [63:0] d;
    logic [7:0]  p;
    int          elem, lane, k, db, li, ls;
    d = '0;
    p = '0;
    elem = int'(a) & ((1 << dpbm_shift(c)) - 1);
    ls = int'(c) - int'(DPBM_W9);
    for (int i = 0; i < DPBM_PHYS_W; i++) begin
      lane = i / DPBM_LANE_W;
      k = i % DPBM_LANE_W;
      db = lane * DPBM_BYTE_W + k;
      if (c < DPBM_W9) begin
        if (k < DPBM_BYTE_W && (db >> c) == elem)
          d[db & ((1 << c) - 1)] = w[i];
      end else if ((lane >> ls) == elem) begin
        li = lane & ((1 << ls) - 1);
        if (k < DPBM_BYTE_W)
          d[li * DPBM_BYTE_W + k] = w[i];
        else if (par)
          p[li] = w[i];
      end
    end
    return {p, d};
  endfunction

endpackage

// ---- logic/dpbm_array.sv ----
// Purpose: storage array with two masked write ports and two read ports
// Assumes: reads are combinational, writes land on the clock edge
// Notes: same-word writes from both ports keep only the port 1 write
`timescale 1ns/1ps
module dpbm_array #(
  parameter int WORDS = 512,
  parameter int AW    = 9
) (
  // Clock
  input  wire logic                 clk_sys,
  // Write side
  input  wire logic [1:0]           wrEn,
  input  wire logic [1:0][AW-1:0]   wrAddr,
  input  wire logic [1:0][71:0]     wrMask,
  input  wire logic [1:0][71:0]     wrData,
  // Read side
  input  wire logic [1:0][AW-1:0]   rdAddr,
  output wire logic [1:0][71:0]     rdWord
);
  import dpbm_pkg::*;

  if (WORDS != (1 << AW)) begin : g_bad_geometry
    $error("dpbm_array: WORDS must equal two to the power AW");
  end

  logic [DPBM_PHYS_W-1:0] store [WORDS];

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (wrEn[i]) begin
        store[wrAddr[i]] <= (store[wrAddr[i]] & ~wrMask[i]) |
                            (wrData[i] & wrMask[i]);
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_rd
    assign rdWord[g] = store[rdAddr[g]];
  end

endmodule // dpbm_array

// ---- logic/dpbm_out_stage.sv ----
// Purpose: output latch and optional pipe register of one port
// Assumes: loadData is the word read at this edge
// Notes: dataOut is a flip-flop in both latch and pipe modes
`timescale 1ns/1ps
module dpbm_out_stage (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Array side
  input  wire logic        loadEn,
  input  wire logic [35:0] loadData,
  input  wire logic        portEnable,
  // Output controls
  input  wire logic        latchReset,
  input  wire logic        pipeSel,
  input  wire logic        pipeClockEnable,
  input  wire logic        pipeReset,
  input  wire logic        pipePrecedence,
  input  wire logic [35:0] initValue,
  // Cascade
  input  wire logic        casSel,
  input  wire logic        casBit,
  // Output
  output wire logic [35:0] dataOut
);
  import dpbm_pkg::*;

  typedef struct packed {
    logic [35:0] latchVal;
    logic [35:0] pipeVal;
    logic [35:0] outVal;
  } dpbm_stage_t;

  dpbm_stage_t stage_reg;
  dpbm_stage_t stage_next;

  always_comb begin
    stage_next = stage_reg;
    if (portEnable && latchReset) begin
      stage_next.latchVal = initValue;
    end else if (loadEn) begin
      stage_next.latchVal = loadData;
    end
    if (pipeSel && (pipePrecedence == DPBM_PREC_RESET || pipeClockEnable)) begin
      if (pipeReset) begin
        stage_next.pipeVal = initValue;
      end else if (pipeClockEnable) begin
        // Upper cascade block takes bit 0 from the lower block
        stage_next.pipeVal = {stage_reg.latchVal[35:1],
                              casSel ? casBit : stage_reg.latchVal[0]};
      end
    end
    // Independent latch and pipe loads of the init value
    stage_next.outVal = pipeSel ? stage_next.pipeVal : stage_next.latchVal;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign dataOut = stage_reg.outVal;

endmodule // dpbm_out_stage

// ---- sim/dpbm_user_port.sv ----
// Purpose: fabric logic driving both memory ports
// Assumes: requests are placed just after a falling edge
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
module dpbm_user_port (
  // Clock
  input  wire logic                             clk_sys,
  // Port drive
  output logic [1:0]                            portEnable,
  output logic [1:0][3:0]                       writeEnable,
  output logic [1:0][dpbm_pkg::DPBM_ADDR_W-1:0] portAddr,
  output logic [1:0]                            topBit,
  output logic [1:0][dpbm_pkg::DPBM_DATA_W-1:0] dataIn,
  output logic [1:0][dpbm_pkg::DPBM_PAR_W-1:0]  parityIn
);
  import dpbm_pkg::*;
  initial begin
    portEnable = 2'h0;
    writeEnable = '0;
    portAddr = '0;
    topBit = 2'h3;
    dataIn = '0;
    parityIn = '0;
  end
  // Scenarios never write one word from both ports at once
  task automatic put(input int g, input logic [3:0] w,
      input logic [14:0] a, input logic [35:0] d);
    writeEnable[g] = w;
    portAddr[g] = a;
    {parityIn[g], dataIn[g]} = d;
  endtask
  // Sets the port enables, then one rising edge takes the request
  task automatic go(input logic [1:0] e);
    portEnable = e;
    @(negedge clk_sys);
  endtask
  // Lets go of both ports once no request follows
  task automatic drop();
    portEnable = 2'h0;
    writeEnable = '0;
    dataIn = ~dataIn;
    parityIn = ~parityIn;
  endtask
endmodule // dpbm_user_port

// ---- sim/dpbm_block_memory_tb.sv ----
// Purpose: self-checking bench of the dual-port block memory
// Assumes: both ports on clk_sys, outputs checked after selected accesses
// Notes: every mode change goes through a reset so config stays static
`timescale 1ns/1ps
module dpbm_block_memory_tb;
  import dpbm_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             split = 1'b0;
  logic [1:0][2:0]  rdW = '0;
  logic [1:0][2:0]  wrW = '0;
  logic [1:0][1:0]  wMode = '0;
  logic [1:0]       pSel = '0;
  logic [1:0]       pPrec = '0;
  logic [1:0]       latchRst = '0;
  logic [1:0]       pipeRst = '0;
  logic [1:0]       pipeCe = '0;
  logic [1:0][35:0] initV = {36'h0, 36'h5_c3c3_3c3c};
  logic [1:0]       en, top, casOut;
  logic [1:0][3:0]  we, parIn, parOut;
  logic [1:0][14:0] addr;
  logic [1:0][31:0] din, dout;
  int               err_total = 0;
  int               cmp_count = 0;

  always #25 clk_sys = ~clk_sys;

  dpbm_user_port fab_u (.clk_sys(clk_sys), .portEnable(en),
    .writeEnable(we), .portAddr(addr), .topBit(top), .dataIn(din),
    .parityIn(parIn));

  dpbm_block_memory dut_u (.clk_sys(clk_sys), .rst(rst),
    .splitReadWriteMode(split), .readWidth(rdW), .writeWidth(wrW),
    .writeMode(wMode), .pipeStageSelect(pSel),
    .pipeResetPrecedence(pPrec), .outputInitValue(initV),
    .portEnable(en), .writeEnable(we), .portAddr(addr),
    .cascadeTopAddressBit(top), .dataIn(din), .parityInBus(parIn),
    .outputLatchReset(latchRst), .outputPipeReset(pipeRst),
    .pipeClockEnable(pipeCe), .cascadeIn(2'h0), .cascadeOut(casOut),
    .dataOut(dout), .parityOutBus(parOut));

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [35:0] out(input int g);
    return {parOut[g], dout[g]};
  endfunction

  task automatic acc(input int g, input logic [3:0] w,
      input logic [14:0] a, input logic [35:0] d);
    fab_u.put(g, w, a, d);
    fab_u.go(2'(1 << g));
  endtask

  task automatic cfg(input logic [2:0] w, input logic [1:0] m,
      input logic p);
    @(negedge clk_sys);
    rdW = {w, w};
    wrW = {w, w};
    wMode = {m, m};
    pSel = {p, p};
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
  endtask

  task automatic t_rw();
    cfg(DPBM_W36, DPBM_NEW_DATA, 1'b0);
    acc(0, 4'hf, 15'h000a, 36'h9_a5a5_1234);
    check(out(0), 36'h9_a5a5_1234);
    acc(1, 4'h0, 15'h000a, 36'h0);
    check(out(1), 36'h9_a5a5_1234);
    check(out(0), 36'h9_a5a5_1234);
    fab_u.drop();
    $display("t_rw done");
  endtask

  task automatic t_modes();
    logic [35:0] vb, v1, v2, exp;
    for (int m = 0; m < 3; m++) begin
      vb = 36'h1_0000_00b0 + 36'(m);
      v1 = 36'h2_0000_0010 + 36'(m);
      v2 = 36'h4_0000_0020 + 36'(m);
      cfg(DPBM_W36, 2'(m), 1'b0);
      acc(0, 4'hf, 15'h0016, vb);
      acc(0, 4'hf, 15'h0014, v1);
      acc(0, 4'h0, 15'h0016, vb);
      acc(0, 4'hf, 15'h0014, v2);
      exp = (m == 0) ? v2 : (m == 1) ? v1 : vb;
      check(out(0), exp);
      acc(0, 4'hf, 15'h0014, v1);
      exp = (m == 0) ? v1 : (m == 1) ? v2 : vb;
      check(out(0), exp);
      acc(1, 4'h0, 15'h0014, 36'h0);
      check(out(1), v1);
      fab_u.drop();
    end
    $display("t_modes done");
  endtask

  task automatic t_enable();
    cfg(DPBM_W36, DPBM_NEW_DATA, 1'b0);
    acc(0, 4'hf, 15'h0018, 36'h3_0000_0001);
    fab_u.put(0, 4'hf, 15'h0018, 36'h5_0000_0002);
    fab_u.go(2'h0);
    check(out(0), 36'h3_0000_0001);
    acc(1, 4'h0, 15'h0018, 36'h0);
    check(out(1), 36'h3_0000_0001);
    acc(0, 4'hf, 15'h001a, 36'hf_ffff_ffff);
    acc(0, 4'h5, 15'h001a, 36'h0);
    acc(1, 4'h0, 15'h001a, 36'h0);
    check(out(1), 36'ha_ff00_ff00);
    fab_u.drop();
    $display("t_enable done");
  endtask

  task automatic t_narrow();
    // x1 element 324 is bit 4 of the x36 word at address 10
    cfg(DPBM_W1, DPBM_NEW_DATA, 1'b0);
    acc(1, 4'h0, 15'h0144, 36'h0);
    check(out(1), 36'h1);
    acc(1, 4'h0, 15'h0143, 36'h0);
    check(out(1), 36'h0);
    fab_u.drop();
    $display("t_narrow done");
  endtask

  task automatic t_pipe();
    pipeCe = 2'h3;
    cfg(DPBM_W36, DPBM_NEW_DATA, 1'b1);
    acc(0, 4'hf, 15'h001c, 36'h6_0000_0abc);
    check(out(0), 36'h0);
    fab_u.go(2'h0);
    check(out(0), 36'h6_0000_0abc);
    pipeCe = 2'h0;
    pipeRst = 2'h1;
    fab_u.go(2'h0);
    check(out(0), initV[0]);
    pipeRst = 2'h0;
    pPrec = 2'h3;
    cfg(DPBM_W36, DPBM_NEW_DATA, 1'b1);
    pipeRst = 2'h1;
    fab_u.go(2'h0);
    check(out(0), 36'h0);
    pipeCe = 2'h1;
    fab_u.go(2'h0);
    check(out(0), initV[0]);
    pipeRst = 2'h0;
    pPrec = 2'h0;
    $display("t_pipe done");
  endtask

  task automatic t_latch();
    cfg(DPBM_W36, DPBM_NEW_DATA, 1'b0);
    // No error decoding in this block, so the latch reset is free
    latchRst = 2'h1;
    fab_u.go(2'h0);
    check(out(0), 36'h0);
    acc(0, 4'h0, 15'h001a, 36'h0);
    check(out(0), initV[0]);
    latchRst = 2'h0;
    fab_u.drop();
    $display("t_latch done");
  endtask

  task automatic t_split();
    split = 1'b1;
    cfg(DPBM_W72, DPBM_NEW_DATA, 1'b0);
    fab_u.put(1, 4'hf, 15'h01f0, 36'hc_8765_4321);
    fab_u.go(2'h0);
    acc(0, 4'hf, 15'h01f0, 36'h3_0fed_cba9);
    acc(1, 4'h0, 15'h01f0, 36'h0);
    check(out(0), 36'h3_0fed_cba9);
    check(out(1), 36'hc_8765_4321);
    fab_u.drop();
    $display("t_split done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    t_rw();
    t_modes();
    t_enable();
    t_narrow();
    t_pipe();
    t_latch();
    t_split();
    test_done();
  end

  // About twenty-six times the expected run
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule // dpbm_block_memory_tb
